//--- hw/adcc_pkg.sv
package adcc_pkg;
  // ---------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_SC1     = 8'h00; // first status control
  localparam logic [7:0] OFS_SC2     = 8'h04; // trigger and compare ctl
  localparam logic [7:0] OFS_RES     = 8'h08; // result, low byte in 7:0
  localparam logic [7:0] OFS_CMP     = 8'h0C; // compare value
  localparam logic [7:0] OFS_CFG     = 8'h10; // clock and format config

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int SC1_DONE    = 7;  // conversion done flag
  localparam int SC1_AIEN    = 6;  // done interrupt enable
  localparam int SC1_CONT    = 5;  // continuous conversion
  localparam int SC1_CH_LSB  = 0;  // channel select, 5 bits
  localparam int SC2_ACT     = 7;  // conversion active
  localparam int SC2_HWT     = 6;  // hardware trigger enable
  localparam int SC2_CFE     = 5;  // compare function enable
  localparam int SC2_GTE     = 4;  // compare greater or equal
  localparam int CFG_SRC_LSB = 0;  // clock source, 2 bits
  localparam int CFG_DIV_LSB = 2;  // clock divide select, 2 bits
  localparam int CFG_FMT_LSB = 4;  // result format, 2 bits
  localparam int CFG_LSMP    = 6;  // long sample

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0]  SC1_RST = 8'h1F; // converter off at reset
  localparam logic [7:0]  SC2_RST = 8'h00;
  localparam logic [11:0] CMP_RST = 12'h000;
  localparam logic [6:0]  CFG_RST = 7'h00;

  // ---------------------------------------------------------------------
  // channel codes, clock sources, formats
  // ---------------------------------------------------------------------
  localparam logic [4:0] CH_OFF   = 5'h1F; // all ones: module off
  localparam logic [4:0] CH_TEMP  = 5'h1A; // temperature_channel
  localparam logic [4:0] CH_BG    = 5'h1B; // bandgap_channel
  localparam logic [4:0] CH_PINS  = 5'h1C; // codes below: 28 inputs
  localparam logic [1:0] SRC_BUS  = 2'h0;  // bus clock
  localparam logic [1:0] SRC_BUS2 = 2'h1;  // bus clock / 2
  localparam logic [1:0] SRC_ALT  = 2'h2;  // alternate_clock_input
  localparam logic [1:0] SRC_ASY  = 2'h3;  // internal_async_conv_clock
  localparam logic [1:0] FMT_8    = 2'h0;
  localparam logic [1:0] FMT_12   = 2'h1;
  localparam logic [1:0] FMT_10   = 2'h2;

  // ---------------------------------------------------------------------
  // timing counts, in conversion clock ticks
  // ---------------------------------------------------------------------
  localparam logic [4:0] SMP_SHORT = 5'd4;
  localparam logic [4:0] SMP_LONG  = 5'd20;

  typedef logic [11:0] adcc_res_t;
endpackage

//--- hw/adcc_sar_if.sv
`timescale 1ns/1ps
interface adcc_sar_if;
  logic      start;     // begin sample then conversion
  logic      abort;     // drop any conversion in progress
  logic      tick;      // one conversion_clock period
  logic      long_smp;  // long sampling phase
  logic      comp;      // comparator: input at or above dac
  logic      sampling;  // sample phase active
  logic      done;      // one-cycle end of conversion
  adcc_pkg::adcc_res_t dac;    // trial code to the dac
  adcc_pkg::adcc_res_t result; // final 12-bit code

  modport ctrl (output start, abort, tick, long_smp, comp,
                input  sampling, done, dac, result);
  modport sar  (input  start, abort, tick, long_smp, comp,
                output sampling, done, dac, result);
endinterface

//--- hw/adcc_clkdiv.sv
`timescale 1ns/1ps
module adcc_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] src_sel,   // clock source
  input  wire logic [1:0] div_sel,   // clock_divide_select
  input  wire logic       alt_in,    // alternate_clock_input
  input  wire logic       async_in,  // internal_async_conv_clock
  input  wire logic       stop_mode, // stop2 or stop3
  output logic            tick       // conversion_clock tick
);
  import adcc_pkg::*;

  // -----------------------------------------------------------------
  // source edges
  // -----------------------------------------------------------------
  logic [1:0] src_in;    // slow clock levels
  logic [1:0] prev_r;    // last levels
  logic [1:0] rise;      // rising edges
  logic       half_r;    // bus clock / 2 phase
  logic [2:0] cnt_r;     // divider count
  logic [2:0] mask;      // divider mask
  logic       src_tick;  // selected source edge
  logic       tick_r;    // registered tick

  assign src_in = {async_in, alt_in};

  // edge detect for each slow source
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_edge
      assign rise[gi] = src_in[gi] & ~prev_r[gi];
    end
  endgenerate

  // alternate clock is held off in stop modes runs in wait
  // the alternate input is the external_reference_clock
  assign src_tick = (src_sel == SRC_BUS)  ? 1'b1 :
                    (src_sel == SRC_BUS2) ? half_r :
                    (src_sel == SRC_ALT)  ? (rise[0] & ~stop_mode) :
                    rise[1];
  assign mask = 3'((4'h1 << div_sel) - 4'h1);

  // source history and divider
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_r <= 2'h0;
      half_r <= 1'b0;
      cnt_r  <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      prev_r <= src_in;
      half_r <= ~half_r;
      if (src_tick)
        cnt_r <= 3'(cnt_r + 3'h1);
      tick_r <= src_tick & ((cnt_r & mask) == mask);
    end
  end

  assign tick = tick_r;

  AST_ALT_STOP: assert property (@(posedge clk) disable iff (!rst_n)
    (src_sel == SRC_ALT) && stop_mode |=> !tick)
    else $error("alternate clock ticked in stop mode");
endmodule

//--- hw/adcc_sar.sv
`timescale 1ns/1ps
module adcc_sar (
  input  wire logic clk,
  input  wire logic rst_n,
  adcc_sar_if.sar   sif
);
  import adcc_pkg::*;

  // -----------------------------------------------------------------
  // successive-approximation sequencer
  // -----------------------------------------------------------------
  typedef enum {SAR_IDLE, SAR_SAMP, SAR_CONV} adcc_sar_e;

  adcc_sar_e  st_r;      // sequencer state
  logic [4:0] smp_r;     // sample ticks left
  logic [3:0] bit_r;     // bit under trial
  adcc_res_t  dac_r;     // trial code
  adcc_res_t  res_r;     // final code
  logic       done_r;    // end pulse
  adcc_res_t  keep;      // trial after comparator
  adcc_res_t  nbit;      // next lower bit

  assign keep = sif.comp ? dac_r : (dac_r & ~(12'h001 << bit_r));
  assign nbit = (bit_r == 4'h0) ? 12'h000 : (12'h001 << (bit_r - 4'h1));

  // one bit resolved per tick, msb first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r   <= SAR_IDLE;
      smp_r  <= 5'h00;
      bit_r  <= 4'h0;
      dac_r  <= 12'h000;
      res_r  <= 12'h000;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (sif.start) begin
        st_r  <= SAR_SAMP;
        smp_r <= sif.long_smp ? SMP_LONG : SMP_SHORT;
        dac_r <= 12'h000;
      end else if (sif.abort) begin
        st_r <= SAR_IDLE;
      end else if (sif.tick) begin
        case (st_r)
          SAR_SAMP: begin
            if (smp_r == 5'h01) begin
              st_r  <= SAR_CONV;
              bit_r <= 4'hB;
              dac_r <= 12'h800;
            end
            smp_r <= 5'(smp_r - 5'h01);
          end
          SAR_CONV: begin
            if (bit_r == 4'h0) begin
              res_r  <= keep;
              done_r <= 1'b1;
              st_r   <= SAR_IDLE;
            end
            dac_r <= keep | nbit;
            bit_r <= 4'(bit_r - 4'h1);
          end
          default: st_r <= SAR_IDLE;
        endcase
      end
    end
  end

  assign sif.sampling = (st_r == SAR_SAMP);
  assign sif.done     = done_r;
  assign sif.dac      = dac_r;
  assign sif.result   = res_r;

  AST_SAR_MSB: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == SAR_SAMP) && sif.tick && (smp_r == 5'h01) && !sif.start
    && !sif.abort |=> (dac_r == 12'h800) && (st_r == SAR_CONV))
    else $error("conversion did not open with msb trial");
endmodule

//--- hw/adcc_top.sv
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
// Operation
// - 28 inputs chosen by 5-bit channel code
// - reserved codes give undefined result
// - codes route temperature sensor and bandgap
// - four selectable conversion clock sources
// - alternate input is external reference clock
// - alternate clock keeps running in wait
// - no alternate clock in stop2, stop3
// - counter overflow starts conversion when enabled
// - trigger works in run, wait, stop3
// - 12-bit linear successive approximation
// - right-justified unsigned 12, 10, 8 bits
// - single or continuous; single returns idle
// - compare less-than or greater-equal, interrupt
// - done flag set, can interrupt
// - operates in wait and stop3
// - control write aborts, and restarts conversion when software-triggered
// - all-ones channel turns converter off
// - done cleared by control write, result read
module adcc_top (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA,
  input  wire logic        COMP_IN,
  input  wire logic        ALT_CLK_IN,
  input  wire logic        ASYNC_CLK_IN,
  input  wire logic        HW_TRIGGER_IN,
  input  wire logic        WAIT_MODE,
  input  wire logic        STOP2_MODE,
  input  wire logic        STOP3_MODE,
  output logic [4:0]       CHANNEL_SELECT,
  output logic             TEMP_SENSOR_EN,
  output logic             BANDGAP_EN,
  output logic             CONV_ENABLE,
  output logic             SAMPLE_HOLD,
  output adcc_pkg::adcc_res_t SAR_DAC,
  output logic             IRQ
);
  import adcc_pkg::*;

  // -------------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------------
  // word hit on a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction

  // all-ones channel code means converter off
  function automatic logic is_off(input logic [4:0] ch);
    is_off = (ch == CH_OFF);
  endfunction

  // -------------------------------------------------------------------
  // register state
  // -------------------------------------------------------------------
  logic        done_r;     // conversion_done_flag
  logic        aien_r;     // done interrupt enable
  logic        cont_r;     // continuous conversion
  logic [4:0]  ch_r;       // channel_select
  logic        hwt_r;      // hardware trigger enable
  logic        cfe_r;      // compare enable
  logic        gte_r;      // compare greater or equal
  adcc_res_t   cmp_r;      // compare value
  logic [1:0]  src_r;      // clock source
  logic [1:0]  div_r;      // clock_divide_select
  logic [1:0]  fmt_r;      // result format
  logic        lsmp_r;     // long sample
  adcc_res_t   res_r;      // stored result
  logic        act_r;      // conversion active
  logic        start_r;    // start pulse to sequencer
  logic        abort_r;    // abort pulse to sequencer
  logic        trig_d_r;   // trigger history
  logic        temp_r;     // temperature sensor route
  logic        bg_r;       // bandgap route
  logic        irq_r;      // interrupt output
  logic        ph_wr_r;    // write data phase pending
  logic [7:0]  ph_a_r;     // data phase address
  logic [31:0] rdata_r;    // read data

  // -------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------
  logic        acc;        // address phase taken
  logic        rd_acc;     // read taken
  logic        wr_sc1;     // control write, data phase
  logic        wr_sc2;
  logic        wr_cmp;
  logic        wr_cfg;
  logic        rd_res;     // result read
  logic [31:0] rd_word;    // read mux

  assign acc    = HSEL & HTRANS[1] & HREADY;
  assign rd_acc = acc & ~HWRITE;
  assign wr_sc1 = ph_wr_r & hit(ph_a_r, OFS_SC1);
  assign wr_sc2 = ph_wr_r & hit(ph_a_r, OFS_SC2);
  assign wr_cmp = ph_wr_r & hit(ph_a_r, OFS_CMP);
  assign wr_cfg = ph_wr_r & hit(ph_a_r, OFS_CFG);
  assign rd_res = rd_acc & hit(HADDR[7:0], OFS_RES);

  // read mux, unmapped words read zero
  assign rd_word =
    hit(HADDR[7:0], OFS_SC1) ? {24'h0, done_r, aien_r, cont_r, ch_r} :
    hit(HADDR[7:0], OFS_SC2) ? {24'h0, act_r, hwt_r, cfe_r, gte_r,
                                4'h0} :
    hit(HADDR[7:0], OFS_RES) ? {20'h0, res_r} :
    hit(HADDR[7:0], OFS_CMP) ? {20'h0, cmp_r} :
    hit(HADDR[7:0], OFS_CFG) ? {25'h0, lsmp_r, fmt_r, div_r, src_r} :
    32'h0;

  // -------------------------------------------------------------------
  // conversion clock and sequencer
  // -------------------------------------------------------------------
  adcc_sar_if  sif ();
  logic        cc_tick;    // conversion_clock tick

  adcc_clkdiv u_clkdiv (
    .clk       (CLK),
    .rst_n     (RESET_N),
    .src_sel   (src_r),
    .div_sel   (div_r),
    .alt_in    (ALT_CLK_IN),
    .async_in  (ASYNC_CLK_IN),
    .stop_mode (STOP2_MODE | STOP3_MODE),
    .tick      (cc_tick)
  );

  adcc_sar u_sar (
    .clk   (CLK),
    .rst_n (RESET_N),
    .sif   (sif)
  );

  assign sif.start    = start_r;
  assign sif.abort    = abort_r;
  assign sif.tick     = cc_tick;
  assign sif.long_smp = lsmp_r;
  assign sif.comp     = COMP_IN;

  // -------------------------------------------------------------------
  // conversion control
  // -------------------------------------------------------------------
  logic [4:0] ch_new;     // channel code being written
  logic       trig_edge;  // one counter overflow
  logic       sw_go;      // software start
  logic       hw_go;      // hardware start
  logic       cont_go;    // continuous restart
  logic       start_nxt;
  logic       abort_nxt;
  logic       act_nxt;
  adcc_res_t  fmt_res;    // formatted result
  logic       cmp_true;   // compare condition met
  logic       store;      // result kept, flag set
  logic       done_nxt;

  assign ch_new    = HWDATA[SC1_CH_LSB +: 5];
  // one conversion per overflow, wait and stop3 alike
  assign trig_edge = HW_TRIGGER_IN & ~trig_d_r;
  // control write restarts unless channel off, hardware trigger on, or stop2
  assign sw_go     = wr_sc1 & ~is_off(ch_new) & ~hwt_r & ~STOP2_MODE;
  assign hw_go     = trig_edge & hwt_r & ~is_off(ch_r) & ~act_r
                     & ~wr_sc1 & ~STOP2_MODE;
  // continuous goes again on the same channel
  assign cont_go   = sif.done & cont_r & ~is_off(ch_r) & ~wr_sc1
                     & ~STOP2_MODE;
  assign start_nxt = sw_go | hw_go | cont_go;
  // stop2 halts, wait and stop3 keep converting
  assign abort_nxt = wr_sc1 | STOP2_MODE;
  assign act_nxt   = start_nxt ? 1'b1 :
                     (abort_nxt | sif.done) ? 1'b0 : act_r;

  // right-justified unsigned result reserved codes convert
  // whatever the mux presents
  assign fmt_res  = (fmt_r == FMT_12) ? sif.result :
                    (fmt_r == FMT_10) ? {2'h0, sif.result[11:2]} :
                    {4'h0, sif.result[11:4]};
  assign cmp_true = gte_r ? (fmt_res >= cmp_r) : (fmt_res < cmp_r);
  assign store    = sif.done & (~cfe_r | cmp_true);
  // a new result wins over a clear in the same cycle
  assign done_nxt = store ? 1'b1 :
                    (wr_sc1 | rd_res) ? 1'b0 : done_r;

  // -------------------------------------------------------------------
  // bus phase and read data
  // -------------------------------------------------------------------
  // zero-wait slave, always OKAY
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ph_wr_r <= 1'b0;
      ph_a_r  <= 8'h00;
      rdata_r <= 32'h0;
    end else begin
      ph_wr_r <= acc & HWRITE;
      if (acc)
        ph_a_r <= HADDR[7:0];
      if (rd_acc)
        rdata_r <= rd_word;
    end
  end

  // -------------------------------------------------------------------
  // software registers
  // -------------------------------------------------------------------
  // control fields, written in the data phase
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      aien_r <= SC1_RST[SC1_AIEN];
      cont_r <= SC1_RST[SC1_CONT];
      ch_r   <= SC1_RST[SC1_CH_LSB +: 5];
      hwt_r  <= SC2_RST[SC2_HWT];
      cfe_r  <= SC2_RST[SC2_CFE];
      gte_r  <= SC2_RST[SC2_GTE];
      cmp_r  <= CMP_RST;
      src_r  <= CFG_RST[CFG_SRC_LSB +: 2];
      div_r  <= CFG_RST[CFG_DIV_LSB +: 2];
      fmt_r  <= CFG_RST[CFG_FMT_LSB +: 2];
      lsmp_r <= CFG_RST[CFG_LSMP];
    end else begin
      if (wr_sc1) begin
        aien_r <= HWDATA[SC1_AIEN];
        cont_r <= HWDATA[SC1_CONT];
        ch_r   <= ch_new;
      end
      if (wr_sc2) begin
        hwt_r <= HWDATA[SC2_HWT];
        cfe_r <= HWDATA[SC2_CFE];
        gte_r <= HWDATA[SC2_GTE];
      end
      if (wr_cmp)
        cmp_r <= HWDATA[11:0];
      if (wr_cfg) begin
        src_r  <= HWDATA[CFG_SRC_LSB +: 2];
        div_r  <= HWDATA[CFG_DIV_LSB +: 2];
        fmt_r  <= HWDATA[CFG_FMT_LSB +: 2];
        lsmp_r <= HWDATA[CFG_LSMP];
      end
    end
  end

  // -------------------------------------------------------------------
  // conversion state and analog controls
  // -------------------------------------------------------------------
  // sequencer pulses, flag, result and mux routes
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      start_r  <= 1'b0;
      abort_r  <= 1'b0;
      act_r    <= 1'b0;
      trig_d_r <= 1'b0;
      done_r   <= SC1_RST[SC1_DONE];
      res_r    <= 12'h000;
      temp_r   <= 1'b0;
      bg_r     <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      start_r  <= start_nxt;
      abort_r  <= abort_nxt;
      act_r    <= act_nxt;
      trig_d_r <= HW_TRIGGER_IN;
      done_r   <= done_nxt;
      if (store)
        res_r <= fmt_res;
      if (wr_sc1) begin
        temp_r <= (ch_new == CH_TEMP);
        bg_r   <= (ch_new == CH_BG);
      end
      irq_r <= done_r & aien_r;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign HREADYOUT      = 1'b1;
  assign HRESP          = 1'b0;
  assign HRDATA         = rdata_r;
  assign CHANNEL_SELECT = ch_r;
  assign TEMP_SENSOR_EN = temp_r;
  assign BANDGAP_EN     = bg_r;
  assign CONV_ENABLE    = act_r;
  assign SAMPLE_HOLD    = sif.sampling;
  assign SAR_DAC        = sif.dac;
  assign IRQ            = irq_r;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  AST_OFF_NO_START: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr_sc1 && is_off(ch_new) |=> !start_r ##1 !act_r)
    else $error("converter started with channel off");

  AST_WRITE_RESTART: assert property (@(posedge CLK)
    disable iff (!RESET_N)
    wr_sc1 && !is_off(ch_new) && !hwt_r && !STOP2_MODE
    |=> start_r && abort_r ##1 act_r)
    else $error("control write did not restart");

  AST_CLEAR: assert property (@(posedge CLK) disable iff (!RESET_N)
    (wr_sc1 || rd_res) && !store |=> !done_r)
    else $error("done flag not cleared");

  AST_SET_WINS: assert property (@(posedge CLK) disable iff (!RESET_N)
    sif.done && !cfe_r |=> done_r && (res_r == $past(fmt_res)))
    else $error("finished conversion not flagged");

  AST_HW_ONE: assert property (@(posedge CLK) disable iff (!RESET_N)
    hw_go |=> start_r ##1 !start_r [*2])
    else $error("overflow did not start exactly one conversion");

  AST_CONT: assert property (@(posedge CLK) disable iff (!RESET_N)
    sif.done && cont_r && !is_off(ch_r) && !wr_sc1 && !STOP2_MODE
    |=> start_r && $stable(ch_r))
    else $error("continuous mode did not restart");

  AST_SINGLE_IDLE: assert property (@(posedge CLK) disable iff (!RESET_N)
    sif.done && !cont_r && !start_nxt |=> !act_r)
    else $error("single conversion did not return idle");

  AST_CMP_GATE: assert property (@(posedge CLK) disable iff (!RESET_N)
    sif.done && cfe_r && !cmp_true && !(wr_sc1 || rd_res)
    |=> done_r == $past(done_r))
    else $error("failed compare changed the done flag");

  AST_FMT: assert property (@(posedge CLK) disable iff (!RESET_N)
    store && (fmt_r == FMT_8) |=> res_r[11:8] == 4'h0)
    else $error("8-bit result not right-justified");

  AST_IRQ: assert property (@(posedge CLK) disable iff (!RESET_N)
    done_r && aien_r |=> IRQ)
    else $error("interrupt missing for done flag");
endmodule

//--- testbench/adcc_analog_model.sv
`timescale 1ns/1ps
module adcc_analog_model (
  input  wire logic                clk,
  input  wire adcc_pkg::adcc_res_t dac,
  input  wire adcc_pkg::adcc_res_t level,
  input  wire logic                fire,
  output logic                     comp,
  output logic                     alt_clk,
  output logic                     asy_clk,
  output logic                     trig
);
  import adcc_pkg::*;
  // comparator: high while the held input is at or above the trial code
  assign comp = (level >= dac);
  // free alternate clock and one overflow pulse per fire, on clk edges
  initial begin
    alt_clk = 1'b0;
    trig    = 1'b0;
    forever @(posedge clk) begin
      alt_clk <= ~alt_clk;
      trig    <= fire;
    end
  end
  // slow internal clock, 140 ns period: divided by eight it keeps the
  // long-sample conversion clock under 1 MHz
  initial begin
    asy_clk = 1'b0;
    forever begin
      repeat (7) @(posedge clk);
      asy_clk <= ~asy_clk;
    end
  end
endmodule

//--- testbench/tb_adc_conversion_control.sv
`timescale 1ns/1ps
module tb_adc_conversion_control;
  import adcc_pkg::*;
  logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, fire = 0;
  logic        wt = 0, stp3 = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, q;
  adcc_res_t   lvl = 0;
  wire logic   hrdy, hrsp, cmp, alt, asy, trg, te, bg, cen, sh, irq;
  wire logic [31:0] hrd;
  wire logic [4:0]  chs;
  adcc_res_t   dac;
  int          n_mismatch = 0, check_count = 0, exp_q[$];
  adcc_top adcc_top_inst (.CLK(clk), .RESET_N(rst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy), .HRESP(hrsp),
    .HRDATA(hrd), .COMP_IN(cmp), .ALT_CLK_IN(alt), .ASYNC_CLK_IN(asy),
    .HW_TRIGGER_IN(trg), .WAIT_MODE(wt), .STOP2_MODE(1'b0),
    .STOP3_MODE(stp3), .CHANNEL_SELECT(chs), .TEMP_SENSOR_EN(te),
    .BANDGAP_EN(bg), .CONV_ENABLE(cen), .SAMPLE_HOLD(sh), .SAR_DAC(dac),
    .IRQ(irq));
  adcc_analog_model adcc_analog_model_inst (.clk(clk), .dac(dac),
    .level(lvl), .fire(fire), .comp(cmp), .alt_clk(alt), .asy_clk(asy),
    .trig(trg));
  // clock and hang guard
  initial forever #5 clk = ~clk;
  initial begin
    #400000;
    n_mismatch++;
    complete_run;
  end
  // one word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrd;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one conversion: channel ch, format f, m = {counter start, compare
  // enable, compare gte}, k = {long sample, divide, source}
  task automatic conv(input logic [4:0] ch, input logic [1:0] f,
                      input logic [2:0] m, input logic [4:0] k);
    int v, i, e;
    v = $urandom % 4096;
    lvl <= v[11:0];
    e = f == FMT_12 ? v : f == FMT_10 ? v >> 2 : v >> 4;
    exp_q.push_back(e);
    xfer(1, OFS_CFG, {25'h0, k[4], f, k[3:0]}, q);
    xfer(1, OFS_CMP, m[0] ? e : 32'hFFF, q);
    xfer(1, OFS_SC2, {25'h0, m, 4'h0}, q);
    xfer(1, OFS_SC1, {26'h1, 1'b0, ch}, q);
    // registered outputs settle one edge after the write lands
    @(posedge clk);
    #1;
    chk(chs, ch);
    chk(te, ch == CH_TEMP);
    chk(bg, ch == CH_BG);
    chk(cen, !m[2]);
    chk(sh, !m[2]);
    if (m[2]) begin
      @(posedge clk) fire <= 1;
      @(posedge clk) fire <= 0;
    end
    for (i = 0; i < 1500; i++) begin
      xfer(0, OFS_SC1, 0, q);
      if (q[SC1_DONE] === 1'b1) break;
    end
    chk(q[SC1_DONE], 1);
    chk(irq, 1);
    xfer(0, OFS_RES, 0, q);
    chk(q, exp_q.pop_front());
    xfer(0, OFS_SC1, 0, q);
    chk(q[SC1_DONE], 0);
    chk(irq, 0);
    xfer(0, OFS_SC2, 0, q);
    chk(q[SC2_ACT], 0);
    chk(cen, 0);
    $display("test ch=%h fmt=%0d mode=%0d finished", ch, f, m);
  endtask
  // reset, SC1 default and an unmapped read, then a conversion per format and start
  initial begin
    void'($urandom(56));
    repeat (6) @(posedge clk);
    rst_n <= 1;
    xfer(0, OFS_SC1, 0, q);
    chk(q, {24'h0, SC1_RST});
    chk(hrsp, 0);
    xfer(0, 8'h14, 0, q);
    chk(q, 0);
    conv(5'($urandom % 24), FMT_8, 3'b010, 5'h05);
    stp3 <= 1;
    conv(CH_BG, FMT_10, 3'b100, 5'h1F);
    conv(CH_TEMP, FMT_12, 3'b011, 5'h1F);
    stp3 <= 0;
    wt <= 1;
    conv(5'h17, 2'h3, 3'b100, 5'h06);
    // compare miss: flag stays clear, converter back to idle
    xfer(1, OFS_SC2, 32'h20, q);
    xfer(1, OFS_CMP, 0, q);
    xfer(1, OFS_SC1, 32'h3, q);
    repeat (150) @(posedge clk);
    xfer(0, OFS_SC1, 0, q);
    chk(q, 32'h3);
    xfer(0, OFS_SC2, 0, q);
    chk(q, 32'h20);
    $display("test compare miss finished");
    // continuous on channel 5, then the all-ones code stops it
    xfer(1, OFS_SC2, 0, q);
    xfer(1, OFS_CFG, 0, q);
    xfer(1, OFS_SC1, 32'h25, q);
    repeat (100) @(posedge clk);
    xfer(0, OFS_SC2, 0, q);
    chk(q[SC2_ACT], 1);
    xfer(0, OFS_SC1, 0, q);
    chk(q, 32'hA5);
    xfer(1, OFS_SC1, 32'h3F, q);
    xfer(0, OFS_RES, 0, q);
    repeat (40) @(posedge clk);
    xfer(0, OFS_SC1, 0, q);
    chk(q, 32'h3F);
    xfer(0, OFS_SC2, 0, q);
    chk(q[SC2_ACT], 0);
    // alternate source chosen while in stop3 must give no ticks
    stp3 <= 1;
    xfer(1, OFS_CFG, 32'h2, q);
    repeat (8) @(posedge clk);
    $display("test continuous, off and stop finished");
    complete_run;
  end
endmodule
